/* File: verilog/hbcfg_pkg.sv */
// Purpose: shared constants and carriers for the bridge config header
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes:   byte address of a register is four times its index
package hbcfg_pkg;

    localparam int unsigned IDX_W = 8;
    localparam int unsigned ADDR_W = 12;

    // Register indices (byte address = index * 4)
    localparam logic [7:0] IDX_MINOR    = 8'h0A;
    localparam logic [7:0] IDX_MAJOR    = 8'h0B;
    localparam logic [7:0] IDX_LATENCY  = 8'h0D;
    localparam logic [7:0] IDX_HEADER   = 8'h0E;
    localparam logic [7:0] IDX_BASE     = 8'h10;
    localparam logic [7:0] IDX_VENDOR   = 8'h2C;
    localparam logic [7:0] IDX_PRODUCT  = 8'h2E;
    localparam logic [7:0] IDX_MISC     = 8'h51;
    localparam logic [7:0] IDX_SIZEMASK = 8'h60;

    // Fixed read values
    localparam logic [7:0] MINOR_VAL   = 8'h00;
    localparam logic [7:0] MAJOR_VAL   = 8'h06;
    localparam logic [7:0] LATENCY_VAL = 8'h00;
    localparam logic [7:0] HEADER_VAL  = 8'h00;

    // Aperture base field layout and misc enable bit
    localparam int unsigned HIGH_LSB = 28;
    localparam int unsigned MID_LSB  = 22;
    localparam int unsigned PF_POS   = 3;
    localparam int unsigned EN_POS   = 1;

    // Reset values
    localparam logic [3:0]  HIGH_RST  = 4'h0;
    localparam logic [5:0]  MID_RST   = 6'h00;
    localparam logic [5:0]  MASK_RST  = 6'h00;
    localparam logic [15:0] TAG_RST   = 16'h0000;
    localparam logic        EN_RST    = 1'b0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Held write request
    typedef struct packed {
        logic [IDX_W-1:0] idx;
        logic [31:0]      data;
        logic [3:0]       strb;
    } hbcfg_wreq_t;

    // Aperture base programmable fields
    typedef struct packed {
        logic [3:0] high;
        logic [5:0] mid;
    } hbcfg_base_t;

endpackage : hbcfg_pkg

/* File: verilog/hbcfg_top.sv */
// Purpose: host bridge configuration header registers with aperture decode
// Assumes: cpu_addr/cpu_req come from logic on ref_clk
// Notes:   aperture_hit follows cpu_req by one cycle
`timescale 1ns/10ps

module hbcfg_top
    import hbcfg_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [31:0]       cpu_addr,
    input  wire logic              cpu_req,
    output logic                   aperture_hit,
    output logic                   aperture_global_enable
);

    // Byte-lane merge, shared by the base word and the two tag words
    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] d,
                                               input logic [3:0]  s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : strb_merge

    // Decode used by both read and write paths
    function automatic logic is_mapped(input logic [IDX_W-1:0] i);
        return i == IDX_MINOR || i == IDX_MAJOR || i == IDX_LATENCY ||
               i == IDX_HEADER || i == IDX_BASE || i == IDX_VENDOR ||
               i == IDX_PRODUCT || i == IDX_MISC || i == IDX_SIZEMASK;
    endfunction : is_mapped

    hbcfg_wreq_t      wreq;
    logic             aw_held;
    logic             w_held;
    hbcfg_base_t      base;
    logic [5:0]       size_mask;
    logic [15:0]      vendor_tag;
    logic [15:0]      product_tag;
    logic             vendor_lock;
    logic             product_lock;
    logic             do_write;
    logic [31:0]      base_word;
    logic [31:0]      next_base;
    logic [5:0]       eff_mid;
    logic [IDX_W-1:0] rd_idx;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign eff_mid  = base.mid & ~size_mask;
    // Masked bits read as zero; lows are hardwired
    assign base_word = {base.high, eff_mid, 18'h00000,
                        1'b1, 2'h0, 1'b0};
    assign next_base = strb_merge(base_word, wreq.data, wreq.strb);

    // Write address channel: taken independently of data
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aw_held       <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held       <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_bvalid;
        end
    end

    // Write data channel
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            w_held       <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held       <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_bvalid;
        end
    end

    // Held request has one writer; readies are low while held, so no overwrite
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wreq <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wreq.idx <= s_axi_awaddr[IDX_W+1:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wreq.data <= s_axi_wdata;
                wreq.strb <= s_axi_wstrb;
            end
        end
    end

    // Write response; unmapped words answer SLVERR
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(wreq.idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Aperture base: only high and unmasked middle bits store
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            base.high <= HIGH_RST;
            base.mid  <= MID_RST;
        end else if (do_write && wreq.idx == IDX_BASE) begin
            base.high <= next_base[31:HIGH_LSB];
            base.mid  <= next_base[27:MID_LSB] & ~size_mask;
        end
    end

    // Size mask and global enable; firmware owns the mask ordering
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            size_mask              <= MASK_RST;
            aperture_global_enable <= EN_RST;
        end else if (do_write) begin
            if (wreq.idx == IDX_SIZEMASK && wreq.strb[0]) begin
                size_mask <= wreq.data[5:0];
            end
            if (wreq.idx == IDX_MISC && wreq.strb[0]) begin
                aperture_global_enable <= wreq.data[EN_POS];
            end
        end
    end

    // Subsystem tags: first write with a strobe in the low two lanes locks, later writes dropped
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            vendor_tag   <= TAG_RST;
            product_tag  <= TAG_RST;
            vendor_lock  <= 1'b0;
            product_lock <= 1'b0;
        end else if (do_write && |wreq.strb[1:0]) begin
            if (wreq.idx == IDX_VENDOR && !vendor_lock) begin
                vendor_tag  <= 16'(strb_merge({16'h0000, vendor_tag}, wreq.data,
                                              wreq.strb));
                vendor_lock <= 1'b1;
            end
            if (wreq.idx == IDX_PRODUCT && !product_lock) begin
                product_tag  <= 16'(strb_merge({16'h0000, product_tag}, wreq.data,
                                               wreq.strb));
                product_lock <= 1'b1;
            end
        end
    end

    // Read path: pure mux, no state touched by reads
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
            rd_idx        <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            rd_idx        <= s_axi_araddr[IDX_W+1:2];
            s_axi_rresp   <= is_mapped(s_axi_araddr[IDX_W+1:2]) ? RESP_OKAY : RESP_SLVERR;
            // Whole word always returned; no byte enables on reads
            unique case (s_axi_araddr[IDX_W+1:2])
                IDX_MINOR:    s_axi_rdata <= {24'h000000, MINOR_VAL};
                IDX_MAJOR:    s_axi_rdata <= {24'h000000, MAJOR_VAL};
                IDX_LATENCY:  s_axi_rdata <= {24'h000000, LATENCY_VAL};
                IDX_HEADER:   s_axi_rdata <= {24'h000000, HEADER_VAL};
                IDX_BASE:     s_axi_rdata <= base_word;
                IDX_VENDOR:   s_axi_rdata <= {16'h0000, vendor_tag};
                IDX_PRODUCT:  s_axi_rdata <= {16'h0000, product_tag};
                IDX_MISC:     s_axi_rdata <= {30'h00000000, aperture_global_enable, 1'b0};
                IDX_SIZEMASK: s_axi_rdata <= {26'h0000000, size_mask};
                default:      s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Aperture decode; writes to it are never errored, so merging is safe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aperture_hit <= 1'b0;
        end else begin
            aperture_hit <= cpu_req && aperture_global_enable &&
                            cpu_addr[31:HIGH_LSB] == base.high &&
                            (cpu_addr[27:MID_LSB] & ~size_mask) == eff_mid;
        end
    end

    // ---- Assertions ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_lookup;
        cpu_req && aperture_global_enable && cpu_addr[31:HIGH_LSB] == base.high;
    endsequence

    property p_minor;
        s_axi_rvalid && rd_idx == IDX_MINOR |-> s_axi_rdata == 32'h00000000;
    endproperty
    a_minor: assert property (p_minor) else $error("minor class nonzero");

    property p_major;
        s_axi_rvalid && rd_idx == IDX_MAJOR |-> s_axi_rdata == 32'h00000006;
    endproperty
    a_major: assert property (p_major) else $error("major class not 06h");

    property p_latency;
        s_axi_rvalid && rd_idx == IDX_LATENCY |-> s_axi_rdata == 32'h00000000;
    endproperty
    a_latency: assert property (p_latency) else $error("latency reads nonzero");

    property p_header;
        s_axi_rvalid && rd_idx == IDX_HEADER |-> s_axi_rdata == 32'h00000000;
    endproperty
    a_header: assert property (p_header) else $error("header reads nonzero");

    property p_base_low;
        s_axi_rvalid && rd_idx == IDX_BASE |-> s_axi_rdata[21:4] == 18'h00000;
    endproperty
    a_base_low: assert property (p_base_low) else $error("base low bits set");

    property p_prefetch;
        s_axi_rvalid && rd_idx == IDX_BASE |-> s_axi_rdata[PF_POS];
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("prefetch bit clear");

    property p_type;
        s_axi_rvalid && rd_idx == IDX_BASE |-> s_axi_rdata[2:0] == 3'h0;
    endproperty
    a_type: assert property (p_type) else $error("type or space bits set");

    property p_masked;
        s_axi_rvalid && rd_idx == IDX_BASE |-> (s_axi_rdata[27:22] & size_mask) == 6'h00;
    endproperty
    a_masked: assert property (p_masked) else $error("masked base bit set");

    property p_hit;
        aperture_hit |-> $past(cpu_req) && $past(aperture_global_enable)
                         && $past(cpu_addr[31:28]) == $past(base.high);
    endproperty
    a_hit: assert property (p_hit) else $error("hit without enable or match");

    property p_lookup;
        s_lookup ##0 ((cpu_addr[27:22] & ~size_mask) == eff_mid) |=> aperture_hit;
    endproperty
    a_lookup: assert property (p_lookup) else $error("matching access missed");

    property p_en_reset;
        @(posedge ref_clk) disable iff (1'b0) $past(srst) |-> !aperture_global_enable;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("enable set after reset");

    property p_vendor_once;
        $past(vendor_lock) |-> $stable(vendor_tag);
    endproperty
    a_vendor_once: assert property (p_vendor_once) else $error("vendor tag changed");

    property p_product_once;
        $past(product_lock) |-> $stable(product_tag);
    endproperty
    a_product_once: assert property (p_product_once) else $error("product tag changed");

    property p_ro_write;
        do_write && wreq.idx == IDX_MAJOR |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("ro write not silent");

    property p_ro_no_effect;
        do_write && (wreq.idx == IDX_MINOR || wreq.idx == IDX_MAJOR ||
                     wreq.idx == IDX_LATENCY || wreq.idx == IDX_HEADER)
            |=> $stable(base) && $stable(size_mask) && $stable(vendor_tag) && $stable(product_tag);
    endproperty
    a_ro_no_effect: assert property (p_ro_no_effect) else $error("ro write changed state");

    property p_rd_side_free;
        s_axi_arvalid && s_axi_arready && !do_write |=> $stable(base) && $stable(size_mask) &&
            $stable(vendor_tag) && $stable(product_tag) && $stable(aperture_global_enable);
    endproperty
    a_rd_side_free: assert property (p_rd_side_free) else $error("read changed a register");

    property p_base_okay;
        do_write && wreq.idx == IDX_BASE |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY;
    endproperty
    a_base_okay: assert property (p_base_okay) else $error("base write errored");

    property p_high_store;
        do_write && wreq.idx == IDX_BASE && wreq.strb[3] |=> base.high == $past(wreq.data[31:HIGH_LSB]);
    endproperty
    a_high_store: assert property (p_high_store) else $error("base high not stored");

    property p_lookup_miss;
        s_lookup ##0 ((cpu_addr[27:22] & ~size_mask) != eff_mid) |=> !aperture_hit;
    endproperty
    a_lookup_miss: assert property (p_lookup_miss) else $error("hit on middle mismatch");

    property p_disabled;
        !aperture_global_enable |=> !aperture_hit;
    endproperty
    a_disabled: assert property (p_disabled) else $error("hit while disabled");

    property p_en_write;
        do_write && wreq.idx == IDX_MISC && wreq.strb[0]
            |=> aperture_global_enable == $past(wreq.data[EN_POS]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable not written");

    property p_vendor_lock;
        do_write && wreq.idx == IDX_VENDOR && |wreq.strb[1:0] |=> vendor_lock;
    endproperty
    a_vendor_lock: assert property (p_vendor_lock) else $error("vendor tag not locked");

    property p_product_lock;
        do_write && wreq.idx == IDX_PRODUCT && |wreq.strb[1:0] |=> product_lock;
    endproperty
    a_product_lock: assert property (p_product_lock) else $error("product tag not locked");

    property p_locks_hold;
        vendor_lock && product_lock |=> vendor_lock && product_lock;
    endproperty
    a_locks_hold: assert property (p_locks_hold) else $error("tag lock released");

endmodule : hbcfg_top

/* File: tb/tb_host_bridge_config_header.sv */
// Purpose: self-checking bench for the bridge config header registers
// Assumes: register byte address is four times the register index
// Notes:   every bus wait is bounded; a timeout counts as a mismatch
`timescale 1ns/10ps

// Compare and count; the tag is the first argument at the call
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD %s expected %h seen %h", name, exp, got); end end

module tb_host_bridge_config_header
    import hbcfg_pkg::*;
;
    logic              ref_clk;
    logic              srst;
    logic [ADDR_W-1:0] s_axi_awaddr;
    logic              s_axi_awvalid;
    logic              s_axi_awready;
    logic [31:0]       s_axi_wdata;
    logic [3:0]        s_axi_wstrb;
    logic              s_axi_wvalid;
    logic              s_axi_wready;
    logic [1:0]        s_axi_bresp;
    logic              s_axi_bvalid;
    logic              s_axi_bready;
    logic [ADDR_W-1:0] s_axi_araddr;
    logic              s_axi_arvalid;
    logic              s_axi_arready;
    logic [31:0]       s_axi_rdata;
    logic [1:0]        s_axi_rresp;
    logic              s_axi_rvalid;
    logic              s_axi_rready;
    logic [31:0]       cpu_addr;
    logic              cpu_req;
    logic              aperture_hit;
    logic              aperture_global_enable;
    int                bad_count;
    int                num_checks;
    logic [31:0]       rd;
    logic [1:0]        rr;

    hbcfg_top u_hbcfg_top (
        .ref_clk(ref_clk), .srst(srst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .cpu_addr(cpu_addr), .cpu_req(cpu_req),
        .aperture_hit(aperture_hit), .aperture_global_enable(aperture_global_enable)
    );

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
        return ADDR_W'({idx, 2'b00});
    endfunction : ba

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // One write; an edge passes first so no signal is driven twice in a step
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] exp_resp);
        int   n;
        logic aw_done;
        logic w_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin aw_done = 1'b1; s_axi_awvalid <= 1'b0; end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin w_done = 1'b1; s_axi_wvalid <= 1'b0; end
        end while (!(aw_done && w_done) && n < 50);
        while (s_axi_bvalid !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        s_axi_bready <= 1'b0;
        if (n >= 50) begin bad_count++; report_and_stop(); end
        `CHK("bresp", exp_resp, s_axi_bresp)
    endtask : axi_write

    // One read; data and response taken at the edge where rvalid is seen
    task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin @(posedge ref_clk); n++; end while (s_axi_arready !== 1'b1 && n < 50);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1 && n < 50) begin @(posedge ref_clk); n++; end
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n >= 50) begin bad_count++; report_and_stop(); end
    endtask : axi_read

    task automatic read_chk(input logic [7:0] idx, input logic [31:0] exp);
        axi_read(ba(idx), rd, rr);
        `CHK("rresp", RESP_OKAY, rr)
        `CHK("rdata", exp, rd)
    endtask : read_chk

    // One processor access; hit is due one cycle after the sampled request
    task automatic probe(input logic [31:0] a, input logic exp);
        @(posedge ref_clk);
        cpu_addr <= a;
        cpu_req <= 1'b1;
        @(posedge ref_clk);
        cpu_req <= 1'b0;
        cpu_addr <= ~a;
        @(posedge ref_clk);
        `CHK("aperture_hit", exp, aperture_hit)
    endtask : probe

    // Reset values, then writes to hardwired places must change nothing
    task automatic t_fixed();
        read_chk(IDX_BASE, 32'h00000008);
        read_chk(IDX_MISC, 32'h00000000);
        `CHK("enable", 1'b0, aperture_global_enable)
        axi_write(ba(IDX_MINOR), 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        axi_write(ba(IDX_MAJOR), 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        axi_write(ba(IDX_LATENCY), 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        axi_write(ba(IDX_HEADER), 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        read_chk(IDX_MINOR, 32'h00000000);
        read_chk(IDX_MAJOR, 32'h00000006);
        read_chk(IDX_LATENCY, 32'h00000000);
        read_chk(IDX_HEADER, 32'h00000000);
    endtask : t_fixed

    // All ones into the base: only the writable high and middle bits stick
    task automatic t_base();
        axi_write(ba(IDX_SIZEMASK), 32'h00000000, 4'hF, RESP_OKAY);
        axi_write(ba(IDX_BASE), 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        read_chk(IDX_BASE, 32'hFFC00008);
        read_chk(IDX_BASE, 32'hFFC00008);
        axi_write(ba(IDX_SIZEMASK), 32'h0000003F, 4'hF, RESP_OKAY);
        read_chk(IDX_BASE, 32'hF0000008);
        axi_write(ba(IDX_SIZEMASK), 32'h00000000, 4'hF, RESP_OKAY);
        axi_write(ba(IDX_BASE), 32'h00000000, 4'hF, RESP_OKAY);
        read_chk(IDX_BASE, 32'h00000008);
    endtask : t_base

    // Decode stays blocked until the global enable is set
    task automatic t_aperture();
        axi_write(ba(IDX_BASE), 32'h5A400000, 4'hF, RESP_OKAY);
        read_chk(IDX_BASE, 32'h5A400008);
        probe(32'h5A400010, 1'b0);
        axi_write(ba(IDX_MISC), 32'h00000002, 4'hF, RESP_OKAY);
        `CHK("enable", 1'b1, aperture_global_enable)
        read_chk(IDX_MISC, 32'h00000002);
        probe(32'h5A400010, 1'b1);
        probe(32'h5A800000, 1'b0);
        probe(32'h6A400000, 1'b0);
        axi_write(ba(IDX_SIZEMASK), 32'h00000001, 4'hF, RESP_OKAY);
        read_chk(IDX_BASE, 32'h5A000008);
        probe(32'h5A000000, 1'b1);
        axi_write(ba(IDX_MISC), 32'h00000000, 4'hF, RESP_OKAY);
        probe(32'h5A000000, 1'b0);
    endtask : t_aperture

    // Board tags take the first write only
    task automatic t_tags();
        axi_write(ba(IDX_VENDOR), 32'h0000ABCD, 4'h3, RESP_OKAY);
        read_chk(IDX_VENDOR, 32'h0000ABCD);
        axi_write(ba(IDX_VENDOR), 32'h00001234, 4'h3, RESP_OKAY);
        read_chk(IDX_VENDOR, 32'h0000ABCD);
        axi_write(ba(IDX_PRODUCT), 32'h00005678, 4'h3, RESP_OKAY);
        read_chk(IDX_PRODUCT, 32'h00005678);
        axi_write(ba(IDX_PRODUCT), 32'h00009999, 4'h3, RESP_OKAY);
        read_chk(IDX_PRODUCT, 32'h00005678);
    endtask : t_tags

    // Unmapped place answers with an error and no data
    task automatic t_unmapped();
        axi_write(12'h3FC, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
        axi_read(12'h3FC, rd, rr);
        `CHK("rresp", RESP_SLVERR, rr)
        `CHK("rdata", 32'h00000000, rd)
    endtask : t_unmapped

    // Main sequence: all inputs set at time zero, reset for 20 cycles
    initial begin
        ref_clk = 1'b0;
        srst = 1'b1;
        bad_count = 0;
        num_checks = 0;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = '0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        cpu_addr = '0;
        cpu_req = 1'b0;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_fixed();
        t_base();
        t_aperture();
        t_tags();
        t_unmapped();
        report_and_stop();
    end
endmodule : tb_host_bridge_config_header
